// ===== rtl/abs_pkg.sv
// package: opcodes, widths and field constants for the bit/skip datapath
package abs_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int NIB_MSB = 3;
  localparam int BYTE_MSB = 7;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_HOT_BASE = 8'h01;
  localparam logic DEST_W = 1'b0;
  localparam logic DEST_F = 1'b1;

  typedef enum logic [3:0] {
    ABS_OP_NONE,
    ABS_OP_ADD_LITERAL,
    ABS_OP_ADD_REGISTER,
    ABS_OP_AND_LITERAL,
    ABS_OP_AND_REGISTER,
    ABS_OP_BIT_CLEAR,
    ABS_OP_BIT_SET,
    ABS_OP_SKIP_IF_ONE,
    ABS_OP_SKIP_IF_ZERO
  } abs_op_t;
endpackage

// ===== rtl/abs_sync.sv
// two-flop synchroniser for a bus of pin levels
module abs_sync
  import abs_pkg::*;
#(
  parameter int WIDTH = DATA_W
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = async_in;
    sync_nxt = meta_r;
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

// ===== rtl/abs_alu.sv
// datapath for add/and, bit set/clear and bit-test-skip instructions
module abs_alu
  import abs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic op_valid,
  input wire abs_op_t op_code,
  input wire logic [DATA_W-1:0] literal_k,
  input wire logic [ADDR_W-1:0] file_addr,
  input wire logic dest_sel,
  input wire logic [BIT_W-1:0] bit_sel,
  input wire logic [DATA_W-1:0] file_rdata,
  input wire logic file_is_io,
  input wire logic [DATA_W-1:0] io_pins,
  output logic [DATA_W-1:0] w_out,
  output logic file_we,
  output logic [ADDR_W-1:0] file_waddr,
  output logic [DATA_W-1:0] file_wdata,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic flags_we,
  output logic skip_next,
  output logic nop_cycle
);
  logic [DATA_W-1:0] pins_sync;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] mask;
  logic [DATA_W:0] sum;
  logic [NIB_MSB+1:0] low_sum;
  logic [DATA_W-1:0] result;
  logic bit_val;

  logic [DATA_W-1:0] w_r, w_nxt;
  logic file_we_r, file_we_nxt;
  logic [ADDR_W-1:0] file_waddr_r, file_waddr_nxt;
  logic [DATA_W-1:0] file_wdata_r, file_wdata_nxt;
  logic c_r, c_nxt;
  logic dc_r, dc_nxt;
  logic z_r, z_nxt;
  logic flags_we_r, flags_we_nxt;
  logic skip_r, skip_nxt;
  logic nop_r, nop_nxt;

  abs_sync #(.WIDTH(DATA_W)) u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .async_in(io_pins),
    .sync_out(pins_sync)
  );

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == ZERO_BYTE;
  endfunction

  always_comb begin
    // pin level wins over latch for io read-modify-write
    operand = file_is_io ? pins_sync : file_rdata;
    mask = ONE_HOT_BASE << bit_sel;
    bit_val = operand[bit_sel];
    low_sum = {1'b0, w_r[NIB_MSB:0]} + {1'b0, literal_k[NIB_MSB:0]};
    sum = {1'b0, w_r} + {1'b0, literal_k};
    if (op_code == ABS_OP_ADD_REGISTER) begin
      low_sum = {1'b0, w_r[NIB_MSB:0]} + {1'b0, operand[NIB_MSB:0]};
      sum = {1'b0, w_r} + {1'b0, operand};
    end
    result = sum[DATA_W-1:0];
    w_nxt = w_r;
    file_we_nxt = 1'b0;
    file_waddr_nxt = file_addr;
    file_wdata_nxt = file_wdata_r;
    c_nxt = c_r;
    dc_nxt = dc_r;
    z_nxt = z_r;
    flags_we_nxt = 1'b0;
    skip_nxt = 1'b0;
    // the slot after a taken skip executes nothing
    nop_nxt = skip_r;
    if (op_valid && !skip_r) begin
      case (op_code)
        ABS_OP_ADD_LITERAL, ABS_OP_ADD_REGISTER: begin
          c_nxt = sum[DATA_W];
          dc_nxt = low_sum[NIB_MSB+1];
          z_nxt = is_zero(result);
          flags_we_nxt = 1'b1;
        end
        ABS_OP_AND_LITERAL: begin
          result = w_r & literal_k;
          z_nxt = is_zero(result);
          flags_we_nxt = 1'b1;
        end
        ABS_OP_AND_REGISTER: begin
          result = w_r & operand;
          z_nxt = is_zero(result);
          flags_we_nxt = 1'b1;
        end
        ABS_OP_BIT_CLEAR: result = operand & ~mask;
        ABS_OP_BIT_SET: result = operand | mask;
        ABS_OP_SKIP_IF_ONE: skip_nxt = bit_val;
        ABS_OP_SKIP_IF_ZERO: skip_nxt = !bit_val;
        default: ;
      endcase
      case (op_code)
        ABS_OP_ADD_LITERAL, ABS_OP_AND_LITERAL: w_nxt = result;
        ABS_OP_ADD_REGISTER, ABS_OP_AND_REGISTER: begin
          if (dest_sel == DEST_W) begin
            w_nxt = result;
          end else begin
            file_we_nxt = 1'b1;
            file_wdata_nxt = result;
          end
        end
        ABS_OP_BIT_CLEAR, ABS_OP_BIT_SET: begin
          file_we_nxt = 1'b1;
          file_wdata_nxt = result;
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      w_r <= W_RESET;
      file_we_r <= 1'b0;
      file_waddr_r <= '0;
      file_wdata_r <= ZERO_BYTE;
      c_r <= 1'b0;
      dc_r <= 1'b0;
      z_r <= 1'b0;
      flags_we_r <= 1'b0;
      skip_r <= 1'b0;
      nop_r <= 1'b0;
    end else begin
      w_r <= w_nxt;
      file_we_r <= file_we_nxt;
      file_waddr_r <= file_waddr_nxt;
      file_wdata_r <= file_wdata_nxt;
      c_r <= c_nxt;
      dc_r <= dc_nxt;
      z_r <= z_nxt;
      flags_we_r <= flags_we_nxt;
      skip_r <= skip_nxt;
      nop_r <= nop_nxt;
    end
  end

  assign w_out = w_r;
  assign file_we = file_we_r;
  assign file_waddr = file_waddr_r;
  assign file_wdata = file_wdata_r;
  assign carry_flag = c_r;
  assign digit_carry_flag = dc_r;
  assign zero_flag = z_r;
  assign flags_we = flags_we_r;
  assign skip_next = skip_r;
  assign nop_cycle = nop_r;
endmodule

// ===== testbench/abs_alu_checker.sv
// assertion checker on the datapath ports
module abs_alu_checker
  import abs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic op_valid,
  input wire abs_op_t op_code,
  input wire logic [7:0] literal_k,
  input wire logic [2:0] bit_sel,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] w_out,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  input wire logic carry_flag,
  input wire logic digit_carry_flag,
  input wire logic zero_flag,
  input wire logic flags_we,
  input wire logic skip_next,
  input wire logic nop_cycle
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  logic t;
  logic [8:0] s;
  logic [4:0] h;
  assign t = op_valid & ~skip_next;
  assign s = w_out + literal_k;
  assign h = w_out[3:0] + literal_k[3:0];
  a_add_lit: assert property (t && op_code == ABS_OP_ADD_LITERAL
    |=> w_out == $past(s[7:0]) && flags_we) else $error("add sum");
  a_add_flags: assert property (t && op_code == ABS_OP_ADD_LITERAL
    |=> {carry_flag, digit_carry_flag} == {$past(s[8]), $past(h[4])}
    && zero_flag == (w_out == 8'h00)) else $error("add flags");
  a_and_lit: assert property (t && op_code == ABS_OP_AND_LITERAL
    |=> w_out == ($past(w_out) & $past(literal_k)) && $stable(carry_flag)
    && zero_flag == (w_out == 8'h00)) else $error("and literal");
  a_bit_set: assert property (t && op_code == ABS_OP_BIT_SET
    |=> file_we && !flags_we && file_wdata ==
    ($past(file_rdata) | (8'h01 << $past(bit_sel)))) else $error("bit set");
  a_bit_clr: assert property (t && op_code == ABS_OP_BIT_CLEAR
    |=> file_we && !flags_we && file_wdata ==
    ($past(file_rdata) & ~(8'h01 << $past(bit_sel)))) else $error("bit clr");
  a_skip_one: assert property (t && op_code == ABS_OP_SKIP_IF_ONE
    |=> skip_next == $past(file_rdata[bit_sel])) else $error("skip one");
  a_skip_zero: assert property (t && op_code == ABS_OP_SKIP_IF_ZERO
    |=> skip_next != $past(file_rdata[bit_sel])) else $error("skip zero");
  a_nop_slot: assert property (skip_next
    |=> nop_cycle && !file_we && !flags_we) else $error("nop slot");
  c_skip: cover property (skip_next ##1 nop_cycle);
  c_write: cover property (file_we && flags_we);
  c_zero: cover property (flags_we && zero_flag && carry_flag);
endmodule

bind abs_alu abs_alu_checker i_abs_alu_checker(.*);

// ===== testbench/abs_file_model.sv
// file register array facing the datapath
module abs_file_model
  import abs_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [6:0] file_addr,
  input wire logic file_we,
  input wire logic [6:0] file_waddr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [128];
  // a write pulse still pending is forwarded, so the next op reads it back
  always @(posedge clk_sys) if (file_we) mem[file_waddr] <= file_wdata;
  assign file_rdata = (file_we && file_waddr == file_addr) ? file_wdata
    : mem[file_addr];
endmodule

// ===== testbench/test_abs_alu.sv
// bench: datapath ops against a file register model
module test_abs_alu
  import abs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, resetn = 1'b0, op_valid = 1'b0, dest_sel = 1'b0;
  logic file_is_io = 1'b0, file_we, carry_flag, digit_carry_flag;
  logic zero_flag, flags_we, skip_next, nop_cycle;
  abs_op_t op_code = ABS_OP_NONE;
  logic [7:0] literal_k = 8'h00, io_pins = 8'h3C;
  logic [7:0] w_out, file_rdata, file_wdata, st;
  logic [6:0] file_addr = 7'h05, file_waddr;
  logic [2:0] bit_sel = 3'h0;
  int fail_count = 0, check_count = 0;
  // pulses and flags packed so one compare covers them all
  assign st = {file_we, flags_we, skip_next, nop_cycle, 1'b0,
    carry_flag, digit_carry_flag, zero_flag};
  abs_alu i_abs_alu(.*);
  abs_file_model i_abs_file_model(.*);
  initial forever #10 clk_sys = ~clk_sys;
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic op(abs_op_t c, logic [7:0] k = 8'h00, logic d = 1'b0,
    logic [2:0] b = 3'h0);
    @(negedge clk_sys);
    {op_valid, op_code, literal_k, dest_sel, bit_sel} = {1'b1, c, k, d, b};
    @(posedge clk_sys);
    #1;
  endtask
  task automatic give_verdict;
    if (fail_count == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    i_abs_file_model.mem[5] = 8'hF0;
    #60 resetn = 1'b1;
    op(ABS_OP_ADD_LITERAL, 8'hF8);
    op(ABS_OP_ADD_LITERAL, 8'h19);
    chk(w_out, 8'h11);
    chk(st, 8'h46);
    op(ABS_OP_AND_LITERAL, 8'hEE);
    chk(st, 8'h47);
    op(ABS_OP_ADD_LITERAL, 8'h20);
    op(ABS_OP_ADD_REGISTER, , 1'b1);
    chk(file_wdata, 8'h10);
    chk({1'b0, file_waddr}, 8'h05);
    chk(st, 8'hC4);
    op(ABS_OP_ADD_REGISTER);
    chk(w_out, 8'h30);
    op(ABS_OP_AND_REGISTER, , 1'b1);
    chk(st, 8'hC0);
    op(ABS_OP_AND_REGISTER);
    chk(w_out, 8'h10);
    op(ABS_OP_BIT_SET, , , 3'h7);
    chk(file_wdata, 8'h90);
    op(ABS_OP_BIT_CLEAR, , , 3'h4);
    chk(file_wdata, 8'h80);
    op(ABS_OP_SKIP_IF_ONE, , , 3'h7);
    chk(st, 8'h20);
    op(ABS_OP_ADD_LITERAL, 8'h01);
    chk(w_out, 8'h10);
    chk(st, 8'h10);
    op(ABS_OP_SKIP_IF_ZERO);
    chk(st, 8'h20);
    op(ABS_OP_NONE);
    op(ABS_OP_SKIP_IF_ZERO, , , 3'h7);
    chk(st, 8'h00);
    op(ABS_OP_ADD_LITERAL, 8'h01);
    chk(w_out, 8'h11);
    file_is_io = 1'b1;
    op(ABS_OP_BIT_SET, , , 3'h0);
    chk(file_wdata, 8'h3D);
    file_is_io = 1'b0;
    give_verdict();
  end
  initial begin
    #20000;
    fail_count++;
    give_verdict();
  end
endmodule
